//--- common/lpm_pkg.sv
// constants, field layout and state type of the low power mode controller
// Contract
// - each of six clocks has its own division ratio, independent of others
// - software stops each peripheral module alone through its own stop bit
// - low power entry needs the mode register setting plus the wait instruction
// - every low power mode ends on an enabled interrupt, CPU runs its handler
// - three operating power modes: high-speed, middle-speed, low-speed
// - chosen operating power mode holds in run, sleep and deep sleep
// - sleep halts CPU; flash, ports run; RAM, DMA, peripherals, oscillators may run
// - deep sleep also halts RAM, DMA, transfer engine and flash, contents kept
// - standby stops main, both on-chip oscillators, PLL and USB PLL
// - standby halts CPU, RAM, DMA, flash, peripherals and holds port states
// - stop register a: bits 9, 13, 14, 19, 28 gate their modules
// - stop register b: bits 0, 4, 10, 19 gate their modules
// - stop register c bit 20; stop register d bits 15, 19, 31
package lpm_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_STANDBY_CONTROL = 8'h00;
  localparam logic [7:0] ADR_MODULE_STOP_A   = 8'h04;
  localparam logic [7:0] ADR_MODULE_STOP_B   = 8'h08;
  localparam logic [7:0] ADR_MODULE_STOP_C   = 8'h0c;
  localparam logic [7:0] ADR_MODULE_STOP_D   = 8'h10;
  localparam logic [7:0] ADR_CLOCK_DIVIDE    = 8'h14;
  localparam logic [7:0] ADR_POWER_MODE      = 8'h18;
  localparam logic [7:0] ADR_STATUS          = 8'h1c;

  // ---------------------------------------------------------------
  // standby control fields
  // ---------------------------------------------------------------
  localparam int BIT_STANDBY_SELECT      = 15;
  localparam int BIT_STANDBY_OUTPUT_KEEP = 14;
  localparam logic [15:0] STANDBY_CONTROL_RESET = 16'h4000;
  localparam logic [15:0] STANDBY_CONTROL_MASK  = 16'hc000;

  // ---------------------------------------------------------------
  // module stop bit positions
  // ---------------------------------------------------------------
  localparam int STOP_MULTI_TIMER  = 9;
  localparam int STOP_PULSE_TIMER0 = 13;
  localparam int STOP_MATCH_TIMER1 = 14;
  localparam int STOP_DAC          = 19;
  localparam int STOP_DMA_DTC      = 28;
  localparam int STOP_CAN          = 0;
  localparam int STOP_SERIAL_IF    = 4;
  localparam int STOP_COMPARATOR   = 10;
  localparam int STOP_USB          = 19;
  localparam int STOP_INFRARED     = 20;
  localparam int STOP_SOUND_IF     = 15;
  localparam int STOP_SD_HOST      = 19;
  localparam int STOP_SECURITY     = 31;

  // ---------------------------------------------------------------
  // clock divide fields: 3-bit code in a 4-bit field per clock, divide by 2**code, code 7 divides as 6
  // ---------------------------------------------------------------
  localparam int DIV_FIELD_W   = 4;
  localparam int DIV_CODE_W    = 3;
  localparam int DIV_MAX_CODE  = 6;
  localparam int DIV_CLOCKS    = 6;
  localparam int DIV_SYSTEM    = 0;
  localparam int DIV_FAST      = 1;
  localparam int DIV_PERIPH    = 2;
  localparam int DIV_CONVERTER = 3;
  localparam int DIV_EXT_BUS   = 4;
  localparam int DIV_FLASH_IF  = 5;
  localparam logic [31:0] CLOCK_DIVIDE_RESET = 32'h0000_0000;
  localparam logic [31:0] CLOCK_DIVIDE_MASK  = 32'h0077_7777;

  // ---------------------------------------------------------------
  // power mode fields
  // ---------------------------------------------------------------
  localparam logic [1:0] OPMODE_HIGH   = 2'h0;
  localparam logic [1:0] OPMODE_MIDDLE = 2'h1;
  localparam logic [1:0] OPMODE_LOW    = 2'h2;
  localparam int BIT_DEEP_SELECT       = 8;

  // ---------------------------------------------------------------
  // oscillator settle time after standby
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int OSC_SETTLE_NS  = 2000;
  localparam int SETTLE_CYC     = (OSC_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_W       = 9;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_DEEP,
    ST_STBY,
    ST_WAKE
  } lp_state_e;

endpackage

//--- hw/clk_ratio_div.sv
// divider producing a one-cycle enable pulse every 2**code cycles, code capped at MAX_CODE
`timescale 1ns/100ps
module clk_ratio_div #(
  parameter int CODE_W   = 3,
  parameter int MAX_CODE = 6
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // control
  input  wire logic              run_i,
  input  wire logic [CODE_W-1:0] code_i,
  // enable pulse
  output logic                   tick_o
);

  if (MAX_CODE < 1 || MAX_CODE >= (1 << CODE_W) || MAX_CODE > 16)
  begin : g_chk
    $error("clk_ratio_div: bad MAX_CODE");
  end

  logic [MAX_CODE-1:0] cnt_q;
  logic [MAX_CODE-1:0] limit;
  logic [CODE_W-1:0]   code_c;

  always_comb
  begin
    code_c = (code_i > CODE_W'(MAX_CODE)) ? CODE_W'(MAX_CODE) : code_i;
    limit  = MAX_CODE'((1 << code_c) - 1);
  end

  // ---------------------------------------------------------------
  // counter and pulse
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end
    else if (cnt_q >= limit)
    begin
      cnt_q  <= '0;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 1'b1;
      tick_o <= 1'b0;
    end
  end

  div_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_o && code_i != '0 && $stable(code_i)) |=> !tick_o)
    else $error("divided enable pulsed twice in a row");

endmodule

//--- hw/low_power_mode_controller.sv
// low power mode controller: dividers, module stop, mode sequencing
`timescale 1ns/100ps
module low_power_mode_controller (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // cpu side
  input  wire logic        wait_exec_i,
  input  wire logic        irq_pending_i,
  input  wire logic        wake_irq_i,
  output logic             cpu_run_o,
  output logic             cpu_resume_o,
  // divided clock enables
  output logic             system_clock_en_o,
  output logic             fast_periph_clock_en_o,
  output logic             periph_clock_en_o,
  output logic             converter_clock_en_o,
  output logic             ext_bus_clock_en_o,
  output logic             flash_if_clock_en_o,
  // module clock enables
  output logic [31:0]      module_en_a_o,
  output logic [31:0]      module_en_b_o,
  output logic [31:0]      module_en_c_o,
  output logic [31:0]      module_en_d_o,
  // domain run controls
  output logic             ram_dma_run_o,
  output logic             flash_run_o,
  output logic             periph_run_o,
  output logic             main_osc_run_o,
  output logic             fast_onchip_osc_run_o,
  output logic             slow_onchip_osc_run_o,
  output logic             pll_run_o,
  output logic             usb_pll_run_o,
  output logic             io_hold_o,
  output logic             io_float_o,
  output logic [1:0]       opmode_o
);

  localparam int WAKE_LAST   = lpm_pkg::SETTLE_CYC;
  localparam int WAKE_RUN_DL = lpm_pkg::SETTLE_CYC + 1;

  localparam logic [31:0] STOP_A_MASK = (32'h1 << lpm_pkg::STOP_MULTI_TIMER)
    | (32'h1 << lpm_pkg::STOP_PULSE_TIMER0) | (32'h1 << lpm_pkg::STOP_MATCH_TIMER1)
    | (32'h1 << lpm_pkg::STOP_DAC) | (32'h1 << lpm_pkg::STOP_DMA_DTC);
  localparam logic [31:0] STOP_B_MASK = (32'h1 << lpm_pkg::STOP_CAN)
    | (32'h1 << lpm_pkg::STOP_SERIAL_IF) | (32'h1 << lpm_pkg::STOP_COMPARATOR)
    | (32'h1 << lpm_pkg::STOP_USB);
  localparam logic [31:0] STOP_C_MASK = 32'h1 << lpm_pkg::STOP_INFRARED;
  localparam logic [31:0] STOP_D_MASK = (32'h1 << lpm_pkg::STOP_SOUND_IF)
    | (32'h1 << lpm_pkg::STOP_SD_HOST) | (32'h1 << lpm_pkg::STOP_SECURITY);

  if (WAKE_LAST < 1 || WAKE_LAST >= (1 << lpm_pkg::SETTLE_W))
  begin : g_chk
    $error("low_power_mode_controller: settle count does not fit");
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0]                  standby_control_q;
  logic [31:0]                  stop_a_q;
  logic [31:0]                  stop_b_q;
  logic [31:0]                  stop_c_q;
  logic [31:0]                  stop_d_q;
  logic [31:0]                  clock_divide_q;
  logic [1:0]                   opmode_q;
  logic                         deep_sel_q;
  lpm_pkg::lp_state_e           state_q;
  lpm_pkg::lp_state_e           state_d;
  logic [lpm_pkg::SETTLE_W-1:0] settle_q;
  logic [5:0]                   div_run;
  logic [5:0]                   ticks;
  logic                         bus_req;
  logic                         bus_wr;
  logic [31:0]                  rd_word;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign bus_wr  = bus_req && we_i;

  always_comb
  begin
    case (adr_i)
      lpm_pkg::ADR_STANDBY_CONTROL: rd_word = {16'h0000, standby_control_q};
      lpm_pkg::ADR_MODULE_STOP_A:   rd_word = stop_a_q;
      lpm_pkg::ADR_MODULE_STOP_B:   rd_word = stop_b_q;
      lpm_pkg::ADR_MODULE_STOP_C:   rd_word = stop_c_q;
      lpm_pkg::ADR_MODULE_STOP_D:   rd_word = stop_d_q;
      lpm_pkg::ADR_CLOCK_DIVIDE:    rd_word = clock_divide_q;
      lpm_pkg::ADR_POWER_MODE:      rd_word = {23'h000000, deep_sel_q, 6'h00, opmode_q};
      lpm_pkg::ADR_STATUS:          rd_word = {29'h00000000, state_q};
      default:                      rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= bus_req;
      dat_o <= (bus_req && !we_i) ? rd_word : 32'h0000_0000;
    end
  end

  // standby control
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      standby_control_q <= lpm_pkg::STANDBY_CONTROL_RESET;
    end
    else if (bus_wr && adr_i == lpm_pkg::ADR_STANDBY_CONTROL)
    begin
      standby_control_q <= 16'(merge({16'h0000, standby_control_q}, dat_i, sel_i))
                           & lpm_pkg::STANDBY_CONTROL_MASK;
    end
  end

  // module stop registers, one bit per module
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stop_a_q <= STOP_A_MASK;
      stop_b_q <= STOP_B_MASK;
      stop_c_q <= STOP_C_MASK;
      stop_d_q <= STOP_D_MASK;
    end
    else if (bus_wr)
    begin
      case (adr_i)
        lpm_pkg::ADR_MODULE_STOP_A: stop_a_q <= merge(stop_a_q, dat_i, sel_i) & STOP_A_MASK;
        lpm_pkg::ADR_MODULE_STOP_B: stop_b_q <= merge(stop_b_q, dat_i, sel_i) & STOP_B_MASK;
        lpm_pkg::ADR_MODULE_STOP_C: stop_c_q <= merge(stop_c_q, dat_i, sel_i) & STOP_C_MASK;
        lpm_pkg::ADR_MODULE_STOP_D: stop_d_q <= merge(stop_d_q, dat_i, sel_i) & STOP_D_MASK;
        default:                    stop_a_q <= stop_a_q;
      endcase
    end
  end

  // divide codes and operating power mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clock_divide_q <= lpm_pkg::CLOCK_DIVIDE_RESET;
      opmode_q       <= lpm_pkg::OPMODE_HIGH;
      deep_sel_q     <= 1'b0;
    end
    else if (bus_wr && adr_i == lpm_pkg::ADR_CLOCK_DIVIDE)
    begin
      clock_divide_q <= merge(clock_divide_q, dat_i, sel_i) & lpm_pkg::CLOCK_DIVIDE_MASK;
    end
    else if (bus_wr && adr_i == lpm_pkg::ADR_POWER_MODE)
    begin
      if (sel_i[0] && dat_i[1:0] != 2'h3)
      begin
        opmode_q <= dat_i[1:0];
      end
      if (sel_i[1])
      begin
        deep_sel_q <= dat_i[lpm_pkg::BIT_DEEP_SELECT];
      end
    end
  end

  // ---------------------------------------------------------------
  // mode sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      lpm_pkg::ST_RUN:
        if (wait_exec_i)
        begin
          if (standby_control_q[lpm_pkg::BIT_STANDBY_SELECT])
            state_d = lpm_pkg::ST_STBY;
          else if (deep_sel_q)
            state_d = lpm_pkg::ST_DEEP;
          else
            state_d = lpm_pkg::ST_SLEEP;
        end
      lpm_pkg::ST_SLEEP,
      lpm_pkg::ST_DEEP:
        if (irq_pending_i)
          state_d = lpm_pkg::ST_RUN;
      lpm_pkg::ST_STBY:
        if (wake_irq_i)
          state_d = lpm_pkg::ST_WAKE;
      lpm_pkg::ST_WAKE:
        if (settle_q == lpm_pkg::SETTLE_W'(1))
          state_d = lpm_pkg::ST_RUN;
      default:
        state_d = lpm_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= lpm_pkg::ST_RUN;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // oscillator settle counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      settle_q <= '0;
    end
    else if (state_q == lpm_pkg::ST_STBY)
    begin
      settle_q <= lpm_pkg::SETTLE_W'(WAKE_LAST);
    end
    else if (settle_q != '0)
    begin
      settle_q <= settle_q - 1'b1;
    end
  end

  // domain controls follow the next state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cpu_run_o             <= 1'b1;
      cpu_resume_o          <= 1'b0;
      ram_dma_run_o         <= 1'b1;
      flash_run_o           <= 1'b1;
      periph_run_o          <= 1'b1;
      main_osc_run_o        <= 1'b1;
      fast_onchip_osc_run_o <= 1'b1;
      slow_onchip_osc_run_o <= 1'b1;
      pll_run_o             <= 1'b1;
      usb_pll_run_o         <= 1'b1;
      io_hold_o             <= 1'b0;
      io_float_o            <= 1'b0;
      opmode_o              <= lpm_pkg::OPMODE_HIGH;
    end
    else
    begin
      cpu_run_o             <= state_d == lpm_pkg::ST_RUN;
      cpu_resume_o          <= state_d == lpm_pkg::ST_RUN && state_q != lpm_pkg::ST_RUN;
      ram_dma_run_o         <= state_d == lpm_pkg::ST_RUN || state_d == lpm_pkg::ST_SLEEP;
      flash_run_o           <= state_d == lpm_pkg::ST_RUN || state_d == lpm_pkg::ST_SLEEP;
      periph_run_o          <= state_d != lpm_pkg::ST_STBY && state_d != lpm_pkg::ST_WAKE;
      main_osc_run_o        <= state_d != lpm_pkg::ST_STBY;
      fast_onchip_osc_run_o <= state_d != lpm_pkg::ST_STBY;
      slow_onchip_osc_run_o <= state_d != lpm_pkg::ST_STBY;
      pll_run_o             <= state_d != lpm_pkg::ST_STBY;
      usb_pll_run_o         <= state_d != lpm_pkg::ST_STBY;
      io_hold_o             <= state_d == lpm_pkg::ST_STBY || state_d == lpm_pkg::ST_WAKE;
      io_float_o            <= (state_d == lpm_pkg::ST_STBY || state_d == lpm_pkg::ST_WAKE)
                               && !standby_control_q[lpm_pkg::BIT_STANDBY_OUTPUT_KEEP];
      opmode_o              <= opmode_q;
    end
  end

  // ---------------------------------------------------------------
  // clock dividers
  // ---------------------------------------------------------------
  always_comb
  begin
    div_run                         = {6{periph_run_o}};
    div_run[lpm_pkg::DIV_SYSTEM]    = ram_dma_run_o;
    div_run[lpm_pkg::DIV_EXT_BUS]   = ram_dma_run_o;
    div_run[lpm_pkg::DIV_FLASH_IF]  = flash_run_o;
  end

  for (genvar g = 0; g < lpm_pkg::DIV_CLOCKS; g++)
  begin : g_div
    clk_ratio_div #(
      .CODE_W   (lpm_pkg::DIV_CODE_W),
      .MAX_CODE (lpm_pkg::DIV_MAX_CODE)
    ) u_div (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (div_run[g]),
      .code_i (clock_divide_q[g*lpm_pkg::DIV_FIELD_W +: lpm_pkg::DIV_CODE_W]),
      .tick_o (ticks[g])
    );
  end

  assign system_clock_en_o      = ticks[lpm_pkg::DIV_SYSTEM];
  assign fast_periph_clock_en_o = ticks[lpm_pkg::DIV_FAST];
  assign periph_clock_en_o      = ticks[lpm_pkg::DIV_PERIPH];
  assign converter_clock_en_o   = ticks[lpm_pkg::DIV_CONVERTER];
  assign ext_bus_clock_en_o     = ticks[lpm_pkg::DIV_EXT_BUS];
  assign flash_if_clock_en_o    = ticks[lpm_pkg::DIV_FLASH_IF];

  // module clock gating
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      module_en_a_o <= 32'h0000_0000;
      module_en_b_o <= 32'h0000_0000;
      module_en_c_o <= 32'h0000_0000;
      module_en_d_o <= 32'h0000_0000;
    end
    else
    begin
      module_en_a_o <= STOP_A_MASK & ~stop_a_q & {32{periph_run_o}};
      module_en_b_o <= STOP_B_MASK & ~stop_b_q & {32{periph_run_o}};
      module_en_c_o <= STOP_C_MASK & ~stop_c_q & {32{periph_run_o}};
      module_en_d_o <= STOP_D_MASK & ~stop_d_q & {32{periph_run_o}};
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_stby_wake;
    state_q == lpm_pkg::ST_STBY && wake_irq_i;
  endsequence

  sequence s_lp_irq;
    (state_q == lpm_pkg::ST_SLEEP || state_q == lpm_pkg::ST_DEEP) && irq_pending_i;
  endsequence

  entry_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == lpm_pkg::ST_RUN && !wait_exec_i) |=> state_q == lpm_pkg::ST_RUN)
    else $error("low power entry without wait");

  irq_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_lp_irq |=> (state_q == lpm_pkg::ST_RUN && cpu_resume_o && cpu_run_o))
    else $error("interrupt did not resume cpu");

  sleep_domains_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == lpm_pkg::ST_SLEEP |-> (!cpu_run_o && flash_run_o && ram_dma_run_o))
    else $error("sleep domain controls wrong");

  deep_domains_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == lpm_pkg::ST_DEEP |-> (!ram_dma_run_o && !flash_run_o && periph_run_o))
    else $error("deep sleep domain controls wrong");

  stby_osc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == lpm_pkg::ST_STBY |-> (!main_osc_run_o && !pll_run_o && !usb_pll_run_o
      && !fast_onchip_osc_run_o && !slow_onchip_osc_run_o))
    else $error("oscillator left running in standby");

  stby_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == lpm_pkg::ST_STBY |-> (!periph_run_o && io_hold_o && !cpu_run_o))
    else $error("standby did not halt and hold");

  wake_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stby_wake |=> (!cpu_run_o && main_osc_run_o)[*8])
    else $error("cpu released before oscillators settled");

  wake_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stby_wake |-> ##WAKE_RUN_DL (cpu_run_o && cpu_resume_o))
    else $error("cpu not released after settle time");

  stop_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ((module_en_a_o & $past(stop_a_q)) == 32'h0
      && (module_en_b_o & $past(stop_b_q)) == 32'h0
      && (module_en_c_o & $past(stop_c_q)) == 32'h0
      && (module_en_d_o & $past(stop_d_q)) == 32'h0))
    else $error("stopped module still clocked");

  opmode_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q != lpm_pkg::ST_RUN && $stable(opmode_q)) |=> opmode_o == $past(opmode_q))
    else $error("operating mode not applied in low power");

endmodule

//--- dv/cpu_side_model.sv
// cpu core model: wait instruction and interrupt sources
`timescale 1ns/100ps
module cpu_side_model (
  // clock
  input  wire logic clk_i,
  // bench commands
  input  wire logic do_wait_i,
  input  wire logic raise_irq_i,
  input  wire logic raise_wake_i,
  // controller side
  input  wire logic cpu_run_i,
  input  wire logic cpu_resume_i,
  output logic      wait_exec_o = 1'b0,
  output logic      irq_pending_o = 1'b0,
  output logic      wake_irq_o = 1'b0
);
  // wait instruction only while the cpu is clocked, after register setup
  always @(posedge clk_i)
    wait_exec_o <= do_wait_i & cpu_run_i;
  // handler entry clears the source
  always @(posedge clk_i)
  begin
    irq_pending_o <= ~cpu_resume_i & (irq_pending_o | raise_irq_i);
    wake_irq_o    <= ~cpu_resume_i & (wake_irq_o | raise_wake_i);
  end
endmodule

//--- dv/test_low_power_mode_controller.sv
// testbench of the low power mode controller
`timescale 1ns/100ps
module test_low_power_mode_controller;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [3:0]  sel_i = 4'hf;
  logic        ack_o, cpu_resume_o, wt, irq, wake;
  logic        do_wait = 1'b0, r_irq = 1'b0, r_wake = 1'b0;
  wire  [5:0]  tk;
  wire  [31:0] en [4];
  wire  [10:0] lv;
  logic [1:0]  opmode_o;
  int          failures = 0, checks_done = 0, seed = 53086, c;
  int          m [9], cnt [6];
  int          msk [9] = '{32'hc000, 32'h1008_6200, 32'h0008_0411, 32'h0010_0000,
                           32'h8008_8000, 32'h0077_7777, 32'h103, 0, 0};

  always #4 clk_i = ~clk_i;

  low_power_mode_controller i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .wait_exec_i(wt), .irq_pending_i(irq), .wake_irq_i(wake),
    .cpu_run_o(lv[10]), .cpu_resume_o(cpu_resume_o),
    .system_clock_en_o(tk[0]), .fast_periph_clock_en_o(tk[1]),
    .periph_clock_en_o(tk[2]), .converter_clock_en_o(tk[3]),
    .ext_bus_clock_en_o(tk[4]), .flash_if_clock_en_o(tk[5]),
    .module_en_a_o(en[0]), .module_en_b_o(en[1]), .module_en_c_o(en[2]),
    .module_en_d_o(en[3]), .ram_dma_run_o(lv[9]), .flash_run_o(lv[8]),
    .periph_run_o(lv[7]), .main_osc_run_o(lv[6]), .fast_onchip_osc_run_o(lv[5]),
    .slow_onchip_osc_run_o(lv[4]), .pll_run_o(lv[3]), .usb_pll_run_o(lv[2]),
    .io_hold_o(lv[1]), .io_float_o(lv[0]), .opmode_o(opmode_o));

  cpu_side_model i_cpu (
    .clk_i(clk_i), .do_wait_i(do_wait), .raise_irq_i(r_irq), .raise_wake_i(r_wake),
    .cpu_run_i(lv[10]), .cpu_resume_i(cpu_resume_o), .wait_exec_o(wt),
    .irq_pending_o(irq), .wake_irq_o(wake));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic bus(input logic w, input int i, input logic [31:0] d);
    int n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= 8'(i * 4);
    dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input int i, input logic [31:0] d);
    bus(1'b1, i, d);
    if (i == 6 && d[1:0] == 2'h3) d[1:0] = m[6][1:0];
    if (i < 7) m[i] = d & msk[i];
  endtask

  task automatic regs_chk;
    for (int i = 0; i < 9; i++)
    begin
      bus(1'b0, i, 32'h0);
      chk(rd, m[i]);
    end
    for (int j = 0; j < 4; j++)
      chk(en[j], ~m[j + 1] & msk[j + 1]);
  endtask

  task automatic waitrun(input int lat);
    int n = 0, s = -1;
    while (lv[10] !== 1'b1 && n < 400)
    begin
      @(posedge clk_i);
      if ((irq | wake) === 1'b1 && s < 0) s = n;
      n++;
    end
    chk(n - s - 1, lat);
    chk(cpu_resume_o, 1'b1);
  endtask

  initial
  begin
    #200000;
    failures++;
    final_report;
  end

  initial
  begin
    foreach (m[i]) m[i] = (i > 0 && i < 5) ? msk[i] : 0;
    m[0] = 32'h4000;
    step(20);
    rst_i <= 1'b0;
    step(1);
    regs_chk;
    $display("test reset done");
    repeat (3)
    begin
      for (int i = 0; i < 9; i++) wr(i, $random(seed));
      regs_chk;
      step(70);
      cnt = '{default: 0};
      repeat (128)
      begin
        @(posedge clk_i);
        foreach (cnt[j]) cnt[j] += tk[j];
      end
      foreach (cnt[j])
      begin
        c = (m[5] >> (4 * j)) & 7;
        chk(cnt[j], 128 >> (c > 6 ? 6 : c));
      end
    end
    $display("test registers and dividers done");
    for (int k = 0; k < 4; k++)
    begin
      wr(0, k == 3 ? 32'hc000 : k == 2 ? 32'h8000 : 32'h0);
      wr(6, (k == 1 ? 32'h100 : 32'h0) | k);
      step(3);
      chk(lv, 11'h7fc);
      do_wait <= 1'b1;
      step(1);
      do_wait <= 1'b0;
      step(4);
      c = k == 0 ? 'h3fc : k == 1 ? 'h0fc : k == 2 ? 'h003 : 'h002;
      chk(lv, c);
      chk(opmode_o, m[6] & 3);
      if (k >= 2) r_wake <= 1'b1;
      else r_irq <= 1'b1;
      step(1);
      r_wake <= 1'b0;
      r_irq  <= 1'b0;
      waitrun(k >= 2 ? 251 : 1);
      step(2);
      chk(lv, 11'h7fc);
      $display("test low power mode %0d done", k);
    end
    final_report;
  end
endmodule
